// ### design/uif_interrupt_level.sv
// top: control, trigger level select, mask, raw/masked status, clear and interrupt output
`timescale 1ns/100ps
module uif_interrupt_level
  import uif_pkg::*;
(
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic             clkEn,
  input  wire logic [11:0]      regAddr,
  input  wire logic [31:0]      regWdata,
  input  wire logic             regWrite,
  input  wire logic             regRead,
  output logic      [31:0]      regRdata,
  input  wire uif_events_type   lineEvents,
  input  wire logic [CNT_W-1:0] rxFillCount,
  input  wire logic [CNT_W-1:0] txFillCount,
  input  wire logic             charBusy,
  output logic                  portActive,
  output logic                  irq
);
  logic [SEL_W-1:0] rxSel_reg;
  logic [SEL_W-1:0] txSel_reg;
  logic [NSRC-1:0]  mask_reg;
  logic [NSRC-1:0]  raw_reg;
  logic [NSRC-1:0]  raw_next;
  logic [NSRC-1:0]  masked;
  logic [NSRC-1:0]  srcEvent;
  logic [NSRC-1:0]  clearBits;
  logic             enable_reg;
  logic             irq_reg;
  logic             portActive_reg;
  logic [31:0]      rdata_reg;
  logic [31:0]      rdataNext;
  uif_run_type      run_reg;
  uif_run_type      run_next;
  logic             rxCross;
  logic             txCross;
  logic             wrCtl;
  logic             wrIfls;
  logic             wrIm;
  logic             wrIcr;
  logic             selCtl;
  logic             selIfls;
  logic             selIm;
  logic             selRis;
  logic             selMis;

  // fill-level crossing detectors
  uif_level_edge #(.IS_RX(1'b1)) rxEdge (
    .clock      (clock),
    .rst_n      (rst_n),
    .clkEn      (clkEn),
    .triggerSel (rxSel_reg),
    .fillCount  (rxFillCount),
    .crossPulse (rxCross)
  );
  uif_level_edge #(.IS_RX(1'b0)) txEdge (
    .clock      (clock),
    .rst_n      (rst_n),
    .clkEn      (clkEn),
    .triggerSel (txSel_reg),
    .fillCount  (txFillCount),
    .crossPulse (txCross)
  );

  // address decode
  assign selCtl  = (regAddr == CTL_OFS);
  assign selIfls = (regAddr == IFLS_OFS);
  assign selIm   = (regAddr == IM_OFS);
  assign selRis  = (regAddr == RIS_OFS);
  assign selMis  = (regAddr == MIS_OFS);
  assign wrCtl   = regWrite && selCtl;
  assign wrIfls  = regWrite && selIfls;
  assign wrIm    = regWrite && selIm;
  assign wrIcr   = regWrite && (regAddr == ICR_OFS);
  // status and mask writes to RIS/MIS fall through with no decode: ignored

  // event vector in the shared layout order
  assign srcEvent[IDX_OE] = lineEvents.overrun;
  assign srcEvent[IDX_BE] = lineEvents.breakErr;
  assign srcEvent[IDX_PE] = lineEvents.parityErr;
  assign srcEvent[IDX_FE] = lineEvents.framingErr;
  assign srcEvent[IDX_RT] = lineEvents.rxTimeout;
  assign srcEvent[IDX_TX] = txCross;
  assign srcEvent[IDX_RX] = rxCross;

  assign clearBits = wrIcr ? regWdata[SRC_HI:SRC_LO] : '0;

  // per-source sticky flag; a same-cycle event beats the clear
  genvar g;
  generate
    for (g = 0; g < NSRC; g++) begin : gSrc
      assign raw_next[g] = srcEvent[g] | (raw_reg[g] & ~clearBits[g]);
      assign masked[g]   = raw_reg[g] & mask_reg[g];
    end
  endgenerate

  // graceful stop: drain the current character before going idle
  always_comb begin
    run_next = run_reg;
    case (run_reg)
      RUN_IDLE:  if (enable_reg) run_next = RUN_ON;
      RUN_ON:    if (!enable_reg) run_next = charBusy ? RUN_DRAIN : RUN_IDLE;
      RUN_DRAIN: if (enable_reg) run_next = RUN_ON;
                 else if (!charBusy) run_next = RUN_IDLE;
      default:   run_next = RUN_IDLE;
    endcase
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    rdataNext = 32'h0;
    if (selCtl) begin
      rdataNext[0] = enable_reg;
    end else if (selIfls) begin
      rdataNext[RXSEL_LO +: SEL_W] = rxSel_reg;
      rdataNext[TXSEL_LO +: SEL_W] = txSel_reg;
    end else if (selIm) begin
      rdataNext[SRC_HI:SRC_LO] = mask_reg;
    end else if (selRis) begin
      rdataNext[SRC_HI:SRC_LO] = raw_reg;
      rdataNext[3:0]           = RIS_LOW;
    end else if (selMis) begin
      rdataNext[SRC_HI:SRC_LO] = masked;
    end
  end

  // configuration registers
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      enable_reg <= 1'b0;
      rxSel_reg  <= SEL_RST;
      txSel_reg  <= SEL_RST;
      mask_reg   <= '0;
    end else if (clkEn) begin
      if (wrCtl) enable_reg <= regWdata[0];
      if (wrIfls) begin
        rxSel_reg <= regWdata[RXSEL_LO +: SEL_W];
        txSel_reg <= regWdata[TXSEL_LO +: SEL_W];
      end
      if (wrIm) mask_reg <= regWdata[SRC_HI:SRC_LO];
    end
  end

  // status, run state and registered outputs
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      raw_reg        <= '0;
      run_reg        <= RUN_IDLE;
      portActive_reg <= 1'b0;
      irq_reg        <= 1'b0;
      rdata_reg      <= 32'h0;
    end else if (clkEn) begin
      raw_reg        <= raw_next;
      run_reg        <= run_next;
      portActive_reg <= (run_next != RUN_IDLE);
      irq_reg   <= |(raw_next & mask_reg);
      rdata_reg <= regRead ? rdataNext : 32'h0;
    end
  end

  assign regRdata   = rdata_reg;
  assign irq        = irq_reg;
  assign portActive = portActive_reg; // own flop, tracks run_reg so no decode glitch reaches the pin
endmodule // uif_interrupt_level

// ### design/uif_level_edge.sv
// crossing detector for one fifo fill level against its trigger
`timescale 1ns/100ps
module uif_level_edge
  import uif_pkg::*;
#(
  parameter bit IS_RX = 1'b1
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic             clkEn,
  input  wire logic [SEL_W-1:0] triggerSel,
  input  wire logic [CNT_W-1:0] fillCount,
  output logic                  crossPulse
);
  logic [CNT_W-1:0] threshold;
  logic             beyond;
  logic             beyond_reg;
  logic             valid;

  // eighths of depth; reserved codes never trigger
  assign valid     = (triggerSel <= 3'h4);
  assign threshold = (triggerSel == 3'h0) ? CNT_W'(FIFO_DEPTH / 8) :
                     (triggerSel == 3'h1) ? CNT_W'(FIFO_DEPTH / 4) :
                     (triggerSel == 3'h2) ? CNT_W'(FIFO_DEPTH / 2) :
                     (triggerSel == 3'h3) ? CNT_W'(FIFO_DEPTH * 3 / 4) :
                                            CNT_W'(FIFO_DEPTH * 7 / 8);
  // rx: at least the level; tx: at most the level
  assign beyond = valid && (IS_RX ? (fillCount >= threshold) : (fillCount <= threshold));

  // remember last comparison so only the transition fires
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      beyond_reg <= 1'b0;
    end else if (clkEn) begin
      beyond_reg <= beyond;
    end
  end

  assign crossPulse = beyond && !beyond_reg;
endmodule // uif_level_edge

// ### design/uif_pkg.sv
// package: register map, field layout and reset values for the interrupt/level block
package uif_pkg;
  localparam logic [11:0] CTL_OFS   = 12'h030;
  localparam logic [11:0] IFLS_OFS  = 12'h034;
  localparam logic [11:0] IM_OFS    = 12'h038;
  localparam logic [11:0] RIS_OFS   = 12'h03c;
  localparam logic [11:0] MIS_OFS   = 12'h040;
  localparam logic [11:0] ICR_OFS   = 12'h044;
  localparam int          SRC_LO    = 4;
  localparam int          SRC_HI    = 10;
  localparam int          NSRC      = 7;
  localparam int          RXSEL_LO  = 3;
  localparam int          TXSEL_LO  = 0;
  localparam int          SEL_W     = 3;
  localparam logic [2:0]  SEL_RST   = 3'h2;
  localparam logic [3:0]  RIS_LOW   = 4'hf;
  localparam int          FIFO_DEPTH = 16;
  localparam int          CNT_W     = 5;
  localparam int          IDX_OE    = 6;
  localparam int          IDX_BE    = 5;
  localparam int          IDX_PE    = 4;
  localparam int          IDX_FE    = 3;
  localparam int          IDX_RT    = 2;
  localparam int          IDX_TX    = 1;
  localparam int          IDX_RX    = 0;
  // error and time-out events, one pulse each
  typedef struct packed {
    logic overrun;
    logic breakErr;
    logic parityErr;
    logic framingErr;
    logic rxTimeout;
  } uif_events_type;
  typedef enum logic [1:0] {
    RUN_IDLE  = 2'b00,
    RUN_ON    = 2'b01,
    RUN_DRAIN = 2'b11
  } uif_run_type;
endpackage

// ### tb/test_uif_interrupt_level.sv
// bench: register-level tests of the interrupt and fifo level block
`timescale 1ns/100ps
module test_uif_interrupt_level
  import uif_pkg::*;
;
  logic             clock = 1'b0;
  logic             rst_n = 1'b0;
  logic             clkEn = 1'b1;
  logic [11:0]      regAddr = 12'h0;
  logic [31:0]      regWdata = 32'h0;
  logic             regWrite = 1'b0;
  logic             regRead = 1'b0;
  logic [31:0]      regRdata;
  uif_events_type   lineEvents = '0;
  logic [CNT_W-1:0] rxFillCount = 5'h0;
  logic [CNT_W-1:0] txFillCount = 5'h10;
  logic             charBusy = 1'b0;
  logic             portActive;
  logic             irq;
  logic [7:0]       takenCount;
  int               n_fail = 0;
  int               n_tests = 0;
  int               cycles = 0;
  int               thr;
  int               frac[5] = '{1, 2, 4, 6, 7};
  always #5 clock = ~clock;
  uif_interrupt_level i_dut (.clock, .rst_n, .clkEn, .regAddr, .regWdata, .regWrite, .regRead,
    .regRdata, .lineEvents, .rxFillCount, .txFillCount, .charBusy, .portActive, .irq);
  uif_irq_ctrl_model i_ic (.clock, .rst_n, .irq, .takenCount);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // accesses leave one idle cycle, so no strobe is driven twice in a step
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1 chk(regRdata, e);
  endtask
  task automatic drive(input logic [4:0] ev, input int r, input int t);
    @(posedge clock);
    lineEvents  <= ev;
    rxFillCount <= CNT_W'(r);
    txFillCount <= CNT_W'(t);
    @(posedge clock);
    lineEvents  <= 5'h0;
  endtask
  task automatic complete_run;
    $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // hang guard, far above the few hundred cycles the tests need
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      complete_run();
    end
  end
  initial begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    rd(IFLS_OFS, 32'h12);
    rd(IM_OFS, 32'h0);
    rd(12'h100, 32'h0);
    wr(IM_OFS, 32'hffffffff);
    rd(IM_OFS, 32'h7f0);
    for (int i = 0; i < 5; i++) begin
      drive(5'h1 << i, 0, 16);
      rd(RIS_OFS, 32'hf | (32'h40 << i));
      // all-ones writes would clear the bit if either address acted as a clear
      wr(RIS_OFS, 32'h7f0);
      wr(MIS_OFS, 32'h7f0);
      rd(MIS_OFS, 32'h40 << i);
      chk({31'h0, irq}, 32'h1);
      wr(ICR_OFS, 32'h40 << i);
      rd(RIS_OFS, 32'hf);
      chk({31'h0, irq}, 32'h0);
    end
    // masked source stays out of the output until its mask is set
    wr(IM_OFS, 32'h0);
    drive(5'h10, 0, 16);
    rd(MIS_OFS, 32'h0);
    wr(IM_OFS, 32'h400);
    rd(RIS_OFS, 32'h40f);
    chk({31'h0, irq}, 32'h1);
    wr(ICR_OFS, 32'h7f0);
    wr(IM_OFS, 32'h30);
    for (int c = 0; c < 8; c++) begin
      wr(IFLS_OFS, 32'(c * 9));
      thr = (c < 5) ? FIFO_DEPTH * frac[c] / 8 : 16;
      drive(5'h0, thr - 1, (c < 5) ? thr + 1 : 0);
      rd(RIS_OFS, 32'hf);
      drive(5'h0, thr, (c < 5) ? thr : 0);
      rd(RIS_OFS, (c < 5) ? 32'h3f : 32'hf);
      wr(ICR_OFS, 32'h30);
      rd(RIS_OFS, 32'hf);
      drive(5'h0, 0, 16);
    end
    rd(IFLS_OFS, 32'h3f);
    // an event pulse while the block is frozen must leave no trace
    @(posedge clock);
    clkEn <= 1'b0;
    drive(5'h10, 0, 16);
    clkEn <= 1'b1;
    rd(RIS_OFS, 32'hf);
    // idle disable stops at once, busy disable drains first
    wr(CTL_OFS, 32'h1);
    @(posedge clock);
    #1 chk({31'h0, portActive}, 32'h1);
    wr(CTL_OFS, 32'h0);
    repeat (2) @(posedge clock);
    #1 chk({31'h0, portActive}, 32'h0);
    wr(CTL_OFS, 32'h1);
    charBusy <= 1'b1;
    wr(CTL_OFS, 32'h0);
    repeat (4) @(posedge clock);
    #1 chk({31'h0, portActive}, 32'h1);
    @(posedge clock);
    charBusy <= 1'b0;
    repeat (3) @(posedge clock);
    #1 chk({31'h0, portActive}, 32'h0);
    chk({31'h0, takenCount != 8'h0}, 32'h1);
    complete_run();
  end
endmodule // test_uif_interrupt_level

// ### tb/uif_interrupt_level_sva.sv
// checker: status, mask and enable relations of the interrupt level block
`timescale 1ns/100ps
module uif_interrupt_level_sva
  import uif_pkg::*;
(
  input wire logic             clock,
  input wire logic             rst_n,
  input wire logic             clkEn,
  input wire logic [11:0]      regAddr,
  input wire logic [31:0]      regWdata,
  input wire logic             regWrite,
  input wire logic             regRead,
  input wire logic [31:0]      regRdata,
  input wire uif_events_type   lineEvents,
  input wire logic [CNT_W-1:0] rxFillCount,
  input wire logic [CNT_W-1:0] txFillCount,
  input wire logic             charBusy,
  input wire logic             portActive,
  input wire logic             irq
);
  logic [6:0] mask_reg;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // read and write decodes, gated like the design's own request taking
  wire rdRis = clkEn && regRead && regAddr == RIS_OFS;
  wire rdMis = clkEn && regRead && regAddr == MIS_OFS;
  wire rdIm  = clkEn && regRead && regAddr == IM_OFS;
  wire offWr = clkEn && regWrite && regAddr == CTL_OFS && !regWdata[0];
  wire icrWr = clkEn && regWrite && regAddr == ICR_OFS;
  // shadow of the mask, so the read-back is not taken from the design
  always_ff @(posedge clock)
    if (!rst_n) mask_reg <= 7'h0;
    else if (clkEn && regWrite && regAddr == IM_OFS) mask_reg <= regWdata[10:4];
  a_ris_reserved: assert property (rdRis |=> regRdata[31:11] == 21'h0 && regRdata[3:0] == RIS_LOW)
    else $error("raw status reserved bits wrong");
  a_mis_reserved: assert property (rdMis |=> regRdata[31:11] == 21'h0 && regRdata[3:0] == 4'h0)
    else $error("masked status reserved bits wrong");
  a_mask_readback: assert property (rdIm |=> regRdata == {21'h0, $past(mask_reg), 4'h0})
    else $error("mask read-back wrong");
  a_mask_blocks: assert property ((mask_reg == 7'h0) [*2] |-> !irq)
    else $error("interrupt with all sources masked");
  a_event_irq: assert property (clkEn && !regWrite && |(lineEvents & mask_reg[6:2]) |=> irq)
    else $error("unmasked event gave no interrupt");
  // a clear in between may legally remove the bit, so only clear-free gaps count
  a_event_raw: assert property (clkEn && lineEvents != 5'h0 ##1 !icrWr ##1 rdRis
    |=> (regRdata[10:6] & $past(lineEvents, 3)) == $past(lineEvents, 3))
    else $error("event missing from raw status");
  a_drain_hold: assert property (charBusy && portActive |=> portActive)
    else $error("port stopped in mid character");
  a_stop_idle: assert property (offWr && !charBusy ##1 clkEn && !charBusy |-> ##[0:1] !portActive)
    else $error("idle port did not stop");
endmodule // uif_interrupt_level_sva
bind uif_interrupt_level uif_interrupt_level_sva i_sva (.clock, .rst_n, .clkEn, .regAddr, .regWdata,
  .regWrite, .regRead, .regRdata, .lineEvents, .rxFillCount, .txFillCount, .charBusy, .portActive, .irq);

// ### tb/uif_irq_ctrl_model.sv
// partner: interrupt controller that counts the requests it takes
`timescale 1ns/100ps
module uif_irq_ctrl_model (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       irq,
  output logic      [7:0] takenCount
);
  logic irqSeen_reg;
  // a level request is taken once, on its rising edge
  always_ff @(posedge clock) begin
    irqSeen_reg <= rst_n && irq;
    if (!rst_n) takenCount <= 8'h0;
    else if (irq && !irqSeen_reg) takenCount <= takenCount + 8'h1;
  end
endmodule // uif_irq_ctrl_model
